// ---- core/ofp_pkg.sv ----
// Package for output fault protection: register map, fields, constants
package ofp_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_DIAG = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_CURR = 8'h14;
    // ----------------------------------------
    // Diagnosis word bit positions (also irq layout)
    // ----------------------------------------
    localparam int DIAG_SHORT = 0;
    localparam int DIAG_OV = 1;
    localparam int DIAG_TSD = 2;
    localparam int DIAG_TW = 3;
    localparam int DIAG_GUV = 4;
    localparam int DIAG_LUV = 5;
    localparam int DIAG_W = 6;
    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    localparam int CTRL_SHORT_DETECT_DISABLE = 0;
    localparam int CTRL_IDLE = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    // ----------------------------------------
    // Status bits
    // ----------------------------------------
    localparam int STAT_STATE_LO = 0;
    localparam int STAT_BRAKE = 2;
    localparam int STAT_DRV_EN = 3;
    localparam int STAT_SS_RESTART = 4;
    localparam int STAT_W = 5;
    // ----------------------------------------
    // Current fields
    // ----------------------------------------
    localparam int CURR_LED_LO = 0;
    localparam int CURR_IN_LO = 2;
    localparam int CURR_W = 4;
    // ----------------------------------------
    // Timing and read data constants
    // ----------------------------------------
    localparam logic [3:0] SHORT_DEBOUNCE_CYCLES = 4'h8;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_BRAKE_SHORT,
        ST_BRAKE_OV,
        ST_OVERTEMP
    } ofp_mode_type;
endpackage

// ---- core/ofp_top.sv ----
// Output fault protection supervisor with APB register access
// ----------------------------------------
// Functional notes
// - Short declared only after feedback low for 8 consecutive switching clocks.
// - Short-detect-disable bit set means no short detection, regulation continues.
// - Short comparator ignored while soft start is below its lock-off point.
// - Short sets short flag and forces brake-low, both low-side switches on.
// - After short shutdown restart automatically through soft start.
// - Reading diagnosis word clears the short flag.
// - Overvoltage sets overvoltage flag and forces brake-low.
// - Overvoltage brake ends once comparator drops below threshold minus hysteresis.
// - Reading diagnosis word clears the overvoltage flag.
// - Gate drivers off if internal or external gate supply undervoltage.
// - In limp home the internal gate supply undervoltage is ignored.
// - In idle only thermal, gate supply and logic supply faults are reported.
// - Overtemperature takes priority over every other fault reaction.
// - Two-bit LED and input current codes readable by host.
// - Thermal shutdown flag latched, drivers restart when overtemperature clears.
// ----------------------------------------
`timescale 1ns/1ns
module ofp_top
    import ofp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sw_clk_en,
    input wire logic feedback_high_sense,
    input wire logic overvoltage_feedback_sense,
    input wire logic gate_supply_internal,
    input wire logic gate_supply_external,
    input wire logic overtemp_shutdown,
    input wire logic overtemp_warning,
    input wire logic logic_supply_uv,
    input wire logic limp_home,
    input wire logic soft_start_locked,
    input wire logic [1:0] led_current_code,
    input wire logic [1:0] input_current_code,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic brake_low,
    output logic gate_drive_enable,
    output logic soft_start_restart,
    output logic irq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] s1_fbh;
        logic [1:0] s1_ov;
        logic [1:0] s1_gi;
        logic [1:0] s1_ge;
        logic [1:0] s1_ot;
        logic [1:0] s1_tw;
        logic [1:0] s1_luv;
        logic [1:0] s1_lh;
        logic [1:0] s1_ss;
        logic [3:0] s1_cur;
        logic [3:0] s2_cur;
        logic [3:0] debounce;
        logic [1:0] warm;
        ofp_mode_type mode;
        logic [DIAG_W-1:0] diag;
        logic [DIAG_W-1:0] irq_status;
        logic [DIAG_W-1:0] irq_mask;
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic brake_low;
        logic gate_drive_enable;
        logic soft_start_restart;
        logic irq;
    } ofp_state_type;

    ofp_state_type st;
    ofp_state_type next_st;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Unused upper bits read as zero
    function automatic logic [31:0] pad_word(input logic [DIAG_W-1:0] v);
        pad_word = RDATA_ZERO;
        pad_word[DIAG_W-1:0] = v;
    endfunction

    // Sticky flags: a new event beats a clear in the same cycle
    function automatic logic [DIAG_W-1:0] flag_update(
        input logic [DIAG_W-1:0] old,
        input logic [DIAG_W-1:0] clr,
        input logic [DIAG_W-1:0] set
    );
        flag_update = (old & ~clr) | set;
    endfunction

    function automatic logic is_brake(input ofp_mode_type m);
        is_brake = (m == ST_BRAKE_SHORT) || (m == ST_BRAKE_OV);
    endfunction

    // ----------------------------------------
    // Synchronised inputs (stage 1 is bit 0, stage 2 is bit 1)
    // ----------------------------------------
    // Only stage 2 is read, so metastability stays in stage 1
    logic fbh_low;
    logic ov_high;
    logic gi_uv;
    logic ge_uv;
    logic ot_sd;
    logic ot_w;
    logic l_uv;
    logic lh;
    logic ss_locked;
    assign fbh_low = st.s1_fbh[1];
    assign ov_high = st.s1_ov[1];
    assign gi_uv = st.s1_gi[1];
    assign ge_uv = st.s1_ge[1];
    assign ot_sd = st.s1_ot[1];
    assign ot_w = st.s1_tw[1];
    assign l_uv = st.s1_luv[1];
    assign lh = st.s1_lh[1];
    assign ss_locked = st.s1_ss[1];

    // ----------------------------------------
    // Decode and event wires
    // ----------------------------------------
    logic apb_access;
    logic apb_setup;
    logic [DIAG_W-1:0] irq_clr;
    logic rd_diag;
    logic short_evt;
    logic [DIAG_W-1:0] events;
    logic [DIAG_W-1:0] idle_mask;
    logic gate_uv;

    always_comb begin
        next_st = st;
        // Inputs from the analog side are asynchronous to clk
        next_st.s1_fbh = {st.s1_fbh[0], feedback_high_sense};
        next_st.s1_ov = {st.s1_ov[0], overvoltage_feedback_sense};
        next_st.s1_gi = {st.s1_gi[0], gate_supply_internal};
        next_st.s1_ge = {st.s1_ge[0], gate_supply_external};
        next_st.s1_ot = {st.s1_ot[0], overtemp_shutdown};
        next_st.s1_tw = {st.s1_tw[0], overtemp_warning};
        next_st.s1_luv = {st.s1_luv[0], logic_supply_uv};
        next_st.s1_lh = {st.s1_lh[0], limp_home};
        next_st.s1_ss = {st.s1_ss[0], soft_start_locked};
        next_st.s1_cur = {led_current_code, input_current_code};
        next_st.s2_cur = st.s1_cur;
        // Drivers stay off until the supply monitors have filled both stages
        next_st.warm = {st.warm[0], 1'b1};

        // ----------------------------------------
        // Short debounce on the switching clock enable
        // ----------------------------------------
        // Counter advances only on switching clock pulses
        short_evt = 1'b0;
        if (st.ctrl[CTRL_SHORT_DETECT_DISABLE]) begin
            next_st.debounce = 4'h0;
        end else if (!ss_locked) begin
            // Ramp below lock-off, a low output is expected
            next_st.debounce = 4'h0;
        end else if (!fbh_low) begin
            next_st.debounce = 4'h0;
        end else if (st.mode != ST_RUN) begin
            next_st.debounce = 4'h0;
        end else if (sw_clk_en) begin
            if (st.debounce == SHORT_DEBOUNCE_CYCLES - 4'h1) begin
                short_evt = 1'b1;
                next_st.debounce = 4'h0;
            end else begin
                next_st.debounce = st.debounce + 4'h1;
            end
        end

        // ----------------------------------------
        // Protective reaction, overtemperature first
        // ----------------------------------------
        next_st.soft_start_restart = 1'b0;
        case (st.mode)
            ST_RUN: begin
                if (ot_sd) begin
                    next_st.mode = ST_OVERTEMP;
                end else if (ov_high) begin
                    next_st.mode = ST_BRAKE_OV;
                end else if (short_evt) begin
                    next_st.mode = ST_BRAKE_SHORT;
                end
            end
            ST_BRAKE_SHORT: begin
                // One brake pulse then restart through soft start
                // Limitation: a lasting short trips again once the ramp relocks
                if (ot_sd) begin
                    next_st.mode = ST_OVERTEMP;
                end else begin
                    next_st.mode = ST_RUN;
                    next_st.soft_start_restart = 1'b1;
                end
            end
            ST_BRAKE_OV: begin
                // Brake held until the comparator drops through its hysteresis
                if (ot_sd) begin
                    next_st.mode = ST_OVERTEMP;
                end else if (!ov_high) begin
                    next_st.mode = ST_RUN;
                    next_st.soft_start_restart = 1'b1;
                end
            end
            ST_OVERTEMP: begin
                // Drivers come back on their own once the die cools
                if (!ot_sd) begin
                    next_st.mode = ST_RUN;
                    next_st.soft_start_restart = 1'b1;
                end
            end
            default: begin
                // Unreachable, recovers to run
                next_st.mode = ST_RUN;
            end
        endcase

        // ----------------------------------------
        // Bridge drive control
        // ----------------------------------------
        // Limp home ignores the internal supply monitor
        gate_uv = ge_uv || (gi_uv && !lh);
        next_st.brake_low = is_brake(next_st.mode);
        // Brake wins over drive, so the bridge never sees both at once
        next_st.gate_drive_enable = st.warm[1] && !gate_uv
            && !st.ctrl[CTRL_IDLE]
            && (next_st.mode != ST_OVERTEMP)
            && !next_st.brake_low;

        // ----------------------------------------
        // Diagnosis events, idle suppression
        // ----------------------------------------
        events = '0;
        events[DIAG_SHORT] = short_evt;
        // Overvoltage not reported while overtemperature owns the bridge
        events[DIAG_OV] = ov_high && !ot_sd;
        events[DIAG_TSD] = ot_sd;
        events[DIAG_TW] = ot_w;
        events[DIAG_GUV] = gate_uv;
        events[DIAG_LUV] = l_uv;
        // Idle keeps thermal and supply reports only
        idle_mask = '1;
        if (st.ctrl[CTRL_IDLE]) begin
            idle_mask[DIAG_SHORT] = 1'b0;
            idle_mask[DIAG_OV] = 1'b0;
        end
        events = events & idle_mask;

        // ----------------------------------------
        // APB slave, zero wait states
        // ----------------------------------------
        apb_setup = psel && !penable;
        apb_access = psel && penable;
        rd_diag = apb_access && !pwrite && paddr == ADDR_DIAG;
        // Decode in setup so data stands registered in the access cycle
        // Ready is one cycle wide, no wait states
        next_st.pready = apb_setup;
        next_st.pslverr = 1'b0;
        next_st.prdata = RDATA_ZERO;
        if (apb_setup) begin
            case (paddr)
                ADDR_DIAG: next_st.prdata = pad_word(st.diag);
                ADDR_CTRL: next_st.prdata[CTRL_W-1:0] = st.ctrl;
                ADDR_STATUS: begin
                    next_st.prdata[STAT_STATE_LO +: 2] = st.mode;
                    next_st.prdata[STAT_BRAKE] = st.brake_low;
                    next_st.prdata[STAT_DRV_EN] = st.gate_drive_enable;
                    next_st.prdata[STAT_SS_RESTART] = st.soft_start_restart;
                end
                ADDR_IRQ_STATUS: next_st.prdata = pad_word(st.irq_status);
                ADDR_IRQ_MASK: next_st.prdata = pad_word(st.irq_mask);
                ADDR_CURR: next_st.prdata[CURR_W-1:0] = st.s2_cur;
                default: next_st.pslverr = 1'b1;
            endcase
        end

        // Clear on read; a new event in the same cycle wins
        next_st.diag = flag_update(st.diag, {DIAG_W{rd_diag}}, events);
        // Thermal shutdown stays latched until read
        next_st.diag[DIAG_TSD] = (st.diag[DIAG_TSD] && !rd_diag) || events[DIAG_TSD];

        // ----------------------------------------
        // Register writes and interrupt
        // ----------------------------------------
        irq_clr = '0;
        if (apb_access && pwrite) begin
            case (paddr)
                ADDR_CTRL: next_st.ctrl = pwdata[CTRL_W-1:0];
                ADDR_IRQ_MASK: next_st.irq_mask = pwdata[DIAG_W-1:0];
                ADDR_IRQ_STATUS: irq_clr = pwdata[DIAG_W-1:0];
                default: irq_clr = '0;
            endcase
        end
        // Write one to clear; a new event still wins
        next_st.irq_status = flag_update(st.irq_status, irq_clr, events);
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign brake_low = st.brake_low;
    assign gate_drive_enable = st.gate_drive_enable;
    assign soft_start_restart = st.soft_start_restart;
    assign irq = st.irq;
endmodule

// ---- verification/ofp_checker_sva.sv ----
// Checker for the fault supervisor ports
`timescale 1ns/1ns
module ofp_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic feedback_high_sense,
    input wire logic overvoltage_feedback_sense,
    input wire logic gate_supply_internal,
    input wire logic gate_supply_external,
    input wire logic overtemp_shutdown,
    input wire logic limp_home,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brake_low,
    input wire logic gate_drive_enable,
    input wire logic soft_start_restart,
    input wire logic irq
);
    // ----
    // Saturating run and age counters
    // ----
    logic [7:0] short_run;
    logic [3:0] flt_age;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            short_run <= 8'h00;
            flt_age <= 4'hF;
        end else begin
            short_run <= !feedback_high_sense ? 8'h00 : short_run + {7'h00, short_run != 8'hFF};
            flt_age <= (overvoltage_feedback_sense || overtemp_shutdown) ? 4'h0 : flt_age + {3'h0, flt_age != 4'hF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_short_wait: assert property ($rose(brake_low) |-> short_run >= 8'h08 || flt_age < 4'h8)
        else $error("brake before debounce");
    chk_short_restart: assert property ($rose(brake_low) && flt_age > 4'h7 |-> ##[1:3] soft_start_restart)
        else $error("no restart after short");
    chk_brake_release: assert property (
        (!feedback_high_sense && !overvoltage_feedback_sense && !overtemp_shutdown)[*8] |-> !brake_low)
        else $error("brake held without fault");
    chk_restart_pulse: assert property (soft_start_restart |=> !soft_start_restart)
        else $error("restart longer than a cycle");
    chk_ext_uv_off: assert property (gate_supply_external[*5] |-> !gate_drive_enable)
        else $error("drive on with external uv");
    chk_int_uv_off: assert property ((gate_supply_internal && !limp_home)[*5] |-> !gate_drive_enable)
        else $error("drive on with internal uv");
    chk_ot_priority: assert property (overtemp_shutdown[*5] |-> !gate_drive_enable && !soft_start_restart)
        else $error("drive or restart during overtemp");
    cover property ($rose(brake_low));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule
bind ofp_top ofp_checker u_chk (.clk(clk), .arst_n(arst_n), .feedback_high_sense(feedback_high_sense),
    .overvoltage_feedback_sense(overvoltage_feedback_sense), .gate_supply_internal(gate_supply_internal),
    .gate_supply_external(gate_supply_external), .overtemp_shutdown(overtemp_shutdown), .limp_home(limp_home),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .brake_low(brake_low),
    .gate_drive_enable(gate_drive_enable), .soft_start_restart(soft_start_restart), .irq(irq));

// ---- verification/ofp_partner.sv ----
// Switching clock and soft start ramp model
`timescale 1ns/1ns
module ofp_partner #(
    parameter int SW_DIV = 2,
    parameter int SS_CYC = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic soft_start_restart,
    output logic sw_clk_en,
    output logic soft_start_locked
);
    // ----
    // Divider and ramp
    // ----
    int div_cnt;
    int ss_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 0;
            ss_cnt <= 0;
            sw_clk_en <= 1'b0;
            soft_start_locked <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == SW_DIV - 1) ? 0 : div_cnt + 1;
            sw_clk_en <= (div_cnt == SW_DIV - 1);
            // Ramp restarts from zero, so detection stays masked during the climb
            ss_cnt <= soft_start_restart ? 0 : ((ss_cnt == SS_CYC) ? ss_cnt : ss_cnt + 1);
            soft_start_locked <= !soft_start_restart && (ss_cnt == SS_CYC);
        end
    end
endmodule

// ---- verification/output_fault_protection_bench.sv ----
// Self-checking bench for the fault supervisor
`timescale 1ns/1ns
module output_fault_protection_bench;
    import ofp_pkg::*;
    logic clk, arst_n, sw_clk_en, feedback_high_sense, overvoltage_feedback_sense, gate_supply_internal;
    logic gate_supply_external, overtemp_shutdown, overtemp_warning, logic_supply_uv, limp_home, soft_start_locked;
    logic psel, penable, pwrite, pready, pslverr, brake_low, gate_drive_enable, soft_start_restart, irq, re;
    logic [1:0] led_current_code, input_current_code;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    int miscompares, checks;
    ofp_top uut (.clk, .arst_n, .sw_clk_en, .feedback_high_sense, .overvoltage_feedback_sense,
        .gate_supply_internal, .gate_supply_external, .overtemp_shutdown, .overtemp_warning, .logic_supply_uv,
        .limp_home, .soft_start_locked, .led_current_code, .input_current_code, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .brake_low, .gate_drive_enable, .soft_start_restart, .irq);
    ofp_partner prt (.clk, .arst_n, .soft_start_restart, .sw_clk_en, .soft_start_locked);
    always #20 clk = !clk;
    // ----
    // Shared tasks
    // ----
    task print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", n, e, s);
            miscompares++;
        end
    endtask
    task tmo;
        chk("wait", 1, 0);
        print_verdict;
    endtask
    // Request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) tmo();
        // Answer stands until the next rising edge and is taken at the negedge before it
        rq = prdata;
        re = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function logic sel(input int s);
        case (s)
            0: sel = brake_low;
            1: sel = soft_start_restart;
            2: sel = gate_drive_enable;
            default: sel = irq;
        endcase
    endfunction
    task wt(input int s, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sel(s) !== v && n < 300);
        if (sel(s) !== v) tmo();
        @(posedge clk);
    endtask
    // ----
    // Scenarios
    // ----
    task t_cur;
        led_current_code <= 2'h2;
        input_current_code <= 2'h1;
        apb(0, ADDR_CTRL, 0);
        chk("ctrl", {30'h0, CTRL_RESET}, rq);
        repeat (3) @(posedge clk);
        apb(0, ADDR_CURR, 0);
        chk("curr", 32'h9, rq);
        apb(1, 8'h40, 32'hF);
        chk("werr", 1, re);
        apb(0, 8'h40, 0);
        chk("rerr", 1, re);
        $display("test cur done");
    endtask
    task t_short;
        apb(1, ADDR_IRQ_MASK, 32'h1);
        feedback_high_sense <= 1'b1;
        wt(0, 1);
        feedback_high_sense <= 1'b0;
        wt(1, 1);
        wt(3, 1);
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h1, rq);
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h0, rq);
        apb(1, ADDR_IRQ_STATUS, 32'h1);
        wt(3, 0);
        apb(1, ADDR_IRQ_MASK, 32'h0);
        $display("test short done");
    endtask
    task t_ov;
        overvoltage_feedback_sense <= 1'b1;
        wt(0, 1);
        repeat (6) @(posedge clk);
        chk("brake", 1, brake_low);
        overvoltage_feedback_sense <= 1'b0;
        wt(1, 1);
        wt(0, 0);
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h2, rq);
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h0, rq);
        $display("test ov done");
    endtask
    task t_dis;
        apb(1, ADDR_CTRL, 32'h1);
        feedback_high_sense <= 1'b1;
        repeat (40) @(posedge clk);
        chk("brake", 0, brake_low);
        feedback_high_sense <= 1'b0;
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h0, rq);
        $display("test disable done");
    endtask
    task t_idle;
        apb(1, ADDR_CTRL, 32'h2);
        overvoltage_feedback_sense <= 1'b1;
        overtemp_warning <= 1'b1;
        logic_supply_uv <= 1'b1;
        repeat (10) @(posedge clk);
        overvoltage_feedback_sense <= 1'b0;
        repeat (6) @(posedge clk);
        apb(0, ADDR_DIAG, 0);
        chk("diag", 32'h28, rq);
        overtemp_warning <= 1'b0;
        logic_supply_uv <= 1'b0;
        apb(1, ADDR_CTRL, 32'h0);
        apb(0, ADDR_DIAG, 0);
        $display("test idle done");
    endtask
    task t_ot;
        overvoltage_feedback_sense <= 1'b1;
        overtemp_shutdown <= 1'b1;
        wt(2, 0);
        repeat (4) @(posedge clk);
        apb(0, ADDR_STATUS, 0);
        chk("mode", 32'h3, rq & 32'h3);
        overvoltage_feedback_sense <= 1'b0;
        overtemp_shutdown <= 1'b0;
        wt(1, 1);
        wt(2, 1);
        apb(0, ADDR_DIAG, 0);
        chk("tsd", 1, rq[DIAG_TSD]);
        apb(0, ADDR_DIAG, 0);
        chk("tsd", 0, rq[DIAG_TSD]);
        $display("test ot done");
    endtask
    task t_uv;
        gate_supply_external <= 1'b1;
        wt(2, 0);
        gate_supply_external <= 1'b0;
        wt(2, 1);
        limp_home <= 1'b1;
        gate_supply_internal <= 1'b1;
        repeat (8) @(posedge clk);
        chk("drive", 1, gate_drive_enable);
        limp_home <= 1'b0;
        wt(2, 0);
        gate_supply_internal <= 1'b0;
        wt(2, 1);
        $display("test uv done");
    endtask
    initial begin
        {clk, arst_n, feedback_high_sense, overvoltage_feedback_sense, gate_supply_internal} = 5'h00;
        {gate_supply_external, overtemp_shutdown, overtemp_warning, logic_supply_uv, limp_home} = 5'h00;
        {psel, penable, pwrite, paddr, pwdata, led_current_code, input_current_code} = 47'h0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_cur;
        t_short;
        t_ov;
        t_dis;
        t_idle;
        t_ot;
        t_uv;
        print_verdict;
    end
endmodule
